/* File: src/esu_endian_swap_unmunge.sv */
// Purpose: endian swap, address unmunge and byte lane decode
// Assumes: all inputs synchronous to core_clk
// Notes: requests pass a fifo, then one registered output stage
//
// How it works
// - big-endian mode passes address untouched and data unswapped
// - little-endian byte transfer xors low address with 111
// - little-endian half-word transfer xors low address with 110
// - little-endian word transfer xors low address with 100
// - double-word transfers never change the low address
// - same correction for pci, memory, rom; lanes follow it
// - column strobes decoded from burst, size, low address, mode
// - pci byte enables decoded from size, low address, mode
// - little-endian mode reverses bytes, never bits inside a byte
// - load reversal exactly undoes store reversal
// - single bytes land at the same address in both modes
// - non-burst byte store at corrected 010 asserts only lane 2
// - half-word at 010 asserts lanes 2 and 3, low byte first in little-endian mode
// - word at 100 asserts strobes 4..7 or all pci enables
// - word data is copied onto both halves of the bus
// - endian select changes only while both buses idle
// - every memory read asserts all eight column strobes
// - double-word store asserts all strobes, never goes to pci
`timescale 1ns/1ps
`include "esu_params.svh"

module esu_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `ESU_FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  // depth must be a power of two: pointers wrap naturally
  logic [WIDTH-1:0] store [DEPTH];
  logic [AW:0] wrPtr_reg;
  logic [AW:0] rdPtr_reg;
  wire empty = (wrPtr_reg == rdPtr_reg);
  wire full = (wrPtr_reg[AW] != rdPtr_reg[AW]) &&
              (wrPtr_reg[AW-1:0] == rdPtr_reg[AW-1:0]);
  wire push = inValid && !full;
  wire pop = outValid && outReady;

  assign inReady = !full;
  assign outValid = !empty;
  assign outData = store[rdPtr_reg[AW-1:0]];

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
    end else begin
      if (push) wrPtr_reg <= wrPtr_reg + 1'b1;
      if (pop) rdPtr_reg <= rdPtr_reg + 1'b1;
    end
  end

  // storage has no reset: only slots behind the write pointer are read
  always_ff @(posedge core_clk) begin
    if (push) store[wrPtr_reg[AW-1:0]] <= inData;
  end
endmodule

module esu_endian_swap_unmunge
  import esu_pkg::*;
#(
  parameter int FIFO_DEPTH = `ESU_FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic cpuReqValid,
  output logic cpuReqReady,
  input wire esu_cpu_req_s cpuReq,
  input wire logic cpuBusIdle,
  input wire logic pciBusIdle,
  input wire logic endianRequestN,
  output logic endianSelectN,
  output logic memReqValid,
  input wire logic memReqReady,
  output esu_mem_req_s memReq,
  input wire logic rdValid,
  input wire logic [63:0] rdData,
  output logic cpuRdValid,
  output logic [63:0] cpuRdData
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [63:0] swapBytes(input logic [63:0] d);
    logic [63:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      r[8*i +: 8] = d[63-8*i -: 8];
    end
    return r;
  endfunction
  function automatic logic [2:0] unmungeMask(input logic [2:0] sz,
                                             input logic le);
    logic [2:0] m;
    m = `ESU_XOR_NONE;
    if (le) begin
      unique case (sz)
        `ESU_SZ_BYTE: m = `ESU_XOR_BYTE;
        `ESU_SZ_HALF: m = `ESU_XOR_HALF;
        `ESU_SZ_WORD: m = `ESU_XOR_WORD;
        default: m = `ESU_XOR_NONE;
      endcase
    end
    return m;
  endfunction
  function automatic logic [7:0] laneMask(input logic [2:0] sz,
                                          input logic [2:0] a);
    logic [7:0] l;
    unique case (sz)
      `ESU_SZ_BYTE: l = `ESU_LANE_BYTE << a;
      `ESU_SZ_HALF: l = `ESU_LANE_HALF << a;
      `ESU_SZ_WORD: l = `ESU_LANE_WORD << a;
      `ESU_SZ_DWORD: l = `ESU_LANE_ALL;
      default: l = `ESU_LANE_NONE;
    endcase
    return l;
  endfunction

  // ----------------------------------------
  // request fifo
  // ----------------------------------------
  esu_cpu_req_s popReq;
  logic popValid;
  logic popReady;
  logic outValid_reg;
  esu_mem_req_s outReq_reg;
  logic endianSelectN_reg;
  logic endianReq_reg;
  logic cpuRdValid_reg;
  logic [63:0] cpuRdData_reg;

  esu_fifo #(
    .WIDTH($bits(esu_cpu_req_s)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .resetn(resetn),
    .inValid(cpuReqValid),
    .inReady(cpuReqReady),
    .inData(cpuReq),
    .outValid(popValid),
    .outReady(popReady),
    .outData(popReq)
  );

  // ----------------------------------------
  // address unmunge, swap and lane decode
  // ----------------------------------------
  wire le = (endianSelectN_reg != `ESU_SEL_BIG);
  wire popFire = popValid && popReady;
  // same correction whatever the target: memory, rom or pci
  wire [2:0] fixLow = popReq.addr[2:0] ^
                      unmungeMask(popReq.transferSize, le);
  wire [31:0] fixAddr = {popReq.addr[31:3], fixLow};
  // whole double-word reversal lands each byte back on its own lane
  wire [63:0] swapped = le ? swapBytes(popReq.data)
                           : popReq.data;
  wire isWord = (popReq.transferSize == `ESU_SZ_WORD);
  wire isDword = (popReq.transferSize == `ESU_SZ_DWORD);
  wire [31:0] wordSel = fixLow[2] ? swapped[31:0] : swapped[63:32];
  wire [63:0] outData = isWord ? {wordSel, wordSel}
                               : swapped;
  wire [7:0] lanes = laneMask(popReq.transferSize, fixLow);
  wire fullRead = !popReq.write || !popReq.burstIndicatorN;
  wire [7:0] casLanes = fullRead ? `ESU_LANE_ALL
                                 : lanes;
  wire [3:0] wordLanes = fixLow[2] ? lanes[7:4] : lanes[3:0];
  // pci carries four bytes at most: double-words and bursts refused
  wire pciRefuse = popReq.toPci && (isDword ||
                   !popReq.burstIndicatorN);
  wire [3:0] cbeN = pciRefuse ? `ESU_CBE_OFF : ~wordLanes;

  esu_mem_req_s nextReq;
  always_comb begin
    nextReq.write = popReq.write;
    nextReq.toPci = popReq.toPci;
    nextReq.pciRefused = pciRefuse;
    nextReq.addr = fixAddr;
    nextReq.data = outData;
    nextReq.casN = popReq.toPci ? `ESU_LANE_ALL : ~casLanes;
    nextReq.cbeN = popReq.toPci ? cbeN : `ESU_CBE_OFF;
  end

  // ----------------------------------------
  // output stage
  // ----------------------------------------
  assign popReady = !outValid_reg || memReqReady;
  assign memReqValid = outValid_reg;
  assign memReq = outReq_reg;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      outValid_reg <= 1'b0;
      outReq_reg <= '0;
    end else if (popReady) begin
      outValid_reg <= popValid;
      if (popValid) outReq_reg <= nextReq;
    end
  end

  // ----------------------------------------
  // endian select
  // ----------------------------------------
  // request is sampled each cycle, acted on only with nothing in flight
  wire allIdle = cpuBusIdle && pciBusIdle && !popValid && !outValid_reg;
  wire endianSelectN_next = allIdle ? endianReq_reg
                                    : endianSelectN_reg;
  assign endianSelectN = endianSelectN_reg;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      endianReq_reg <= `ESU_REQ_IDLE;
      endianSelectN_reg <= `ESU_SEL_BIG;
    end else begin
      endianReq_reg <= endianRequestN;
      endianSelectN_reg <= endianSelectN_next;
    end
  end

  // ----------------------------------------
  // load data return
  // ----------------------------------------
  // reversal is its own inverse, so loads undo stores exactly
  wire [63:0] cpuRdData_next = le ? swapBytes(rdData)
                                  : rdData;
  assign cpuRdValid = cpuRdValid_reg;
  assign cpuRdData = cpuRdData_reg;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cpuRdValid_reg <= 1'b0;
      cpuRdData_reg <= '0;
    end else begin
      cpuRdValid_reg <= rdValid;
      if (rdValid) cpuRdData_reg <= cpuRdData_next;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  property p_be_pass;
    popFire && !le |=> memReq.addr == $past(popReq.addr) &&
      ($past(isWord) ? memReq.data == {2{$past(popReq.addr[2]) ?
      $past(popReq.data[31:0]) : $past(popReq.data[63:32])}} :
      memReq.data == $past(popReq.data));
  endproperty
  a_be_pass: assert property (p_be_pass)
    else $error("big-endian request altered");
  property p_byte_xor;
    popFire && le && popReq.transferSize == `ESU_SZ_BYTE |=>
      memReq.addr[2:0] == ($past(popReq.addr[2:0]) ^ `ESU_XOR_BYTE);
  endproperty
  a_byte_xor: assert property (p_byte_xor)
    else $error("byte address not unmunged");
  property p_half_xor;
    popFire && le && popReq.transferSize == `ESU_SZ_HALF |=>
      memReq.addr[2:0] == ($past(popReq.addr[2:0]) ^ `ESU_XOR_HALF);
  endproperty
  a_half_xor: assert property (p_half_xor)
    else $error("half-word address not unmunged");
  property p_word_xor;
    popFire && le && isWord |=>
      memReq.addr[2:0] == ($past(popReq.addr[2:0]) ^ `ESU_XOR_WORD);
  endproperty
  a_word_xor: assert property (p_word_xor)
    else $error("word address not unmunged");
  property p_dword_addr;
    popFire && isDword |=> memReq.addr == $past(popReq.addr);
  endproperty
  a_dword_addr: assert property (p_dword_addr)
    else $error("double-word address changed");
  property p_dword_swap;
    popFire && le && isDword |=>
      memReq.data == swapBytes($past(popReq.data));
  endproperty
  a_dword_swap: assert property (p_dword_swap)
    else $error("double-word not byte reversed");
  property p_byte_lane2;
    popFire && popReq.write && !popReq.toPci && popReq.burstIndicatorN
      && popReq.transferSize == `ESU_SZ_BYTE && fixLow == 3'h2 |=>
      memReq.casN == ~(`ESU_LANE_BYTE << 2);
  endproperty
  a_byte_lane2: assert property (p_byte_lane2)
    else $error("byte at 010 wrong strobe");
  property p_word_high;
    popFire && popReq.write && popReq.toPci && isWord &&
      popReq.burstIndicatorN |=> memReq.cbeN == 4'h0 &&
      memReq.data[63:32] == memReq.data[31:0];
  endproperty
  a_word_high: assert property (p_word_high)
    else $error("pci word lanes or doubling wrong");
  property p_read_all;
    popFire && !popReq.write && !popReq.toPci |=> memReq.casN == 8'h00;
  endproperty
  a_read_all: assert property (p_read_all)
    else $error("memory read lacks full strobes");
  property p_dword_pci;
    popFire && popReq.toPci && isDword |=>
      memReq.pciRefused && memReq.cbeN == `ESU_CBE_OFF;
  endproperty
  a_dword_pci: assert property (p_dword_pci)
    else $error("double-word forwarded to pci");
  property p_sel_idle;
    $changed(endianSelectN) |-> $past(allIdle);
  endproperty
  a_sel_idle: assert property (p_sel_idle)
    else $error("endian select changed while busy");
  property p_load_swap;
    rdValid && le ##1 le |-> cpuRdValid &&
      swapBytes(cpuRdData) == $past(rdData);
  endproperty
  a_load_swap: assert property (p_load_swap)
    else $error("load reversal does not undo store");
  c_le_half: cover property (popFire && le &&
    popReq.transferSize == `ESU_SZ_HALF);
  c_mode_flip: cover property ($changed(endianSelectN));
  c_fifo_full: cover property (cpuReqValid && !cpuReqReady);
  c_pci_word: cover property (popFire && popReq.toPci && isWord);
endmodule

/* File: src/esu_params.svh */
// Purpose: constants of the endian swap and unmunge datapath
// Assumes: low address bits [2:0] are the processor's bits 29..31
// Notes: definitions only
`ifndef ESU_PARAMS_SVH
`define ESU_PARAMS_SVH
// ----------------------------------------
// transfer size codes
// ----------------------------------------
`define ESU_SZ_DWORD 3'h0
`define ESU_SZ_BYTE 3'h1
`define ESU_SZ_HALF 3'h2
`define ESU_SZ_WORD 3'h4
// ----------------------------------------
// unmunge xor masks
// ----------------------------------------
`define ESU_XOR_BYTE 3'h7
`define ESU_XOR_HALF 3'h6
`define ESU_XOR_WORD 3'h4
`define ESU_XOR_NONE 3'h0
// ----------------------------------------
// byte lane patterns, bit n is address n
// ----------------------------------------
`define ESU_LANE_BYTE 8'h01
`define ESU_LANE_HALF 8'h03
`define ESU_LANE_WORD 8'h0f
`define ESU_LANE_ALL 8'hff
`define ESU_LANE_NONE 8'h00
`define ESU_CBE_OFF 4'hf
// ----------------------------------------
// reset values and sizes
// ----------------------------------------
`define ESU_SEL_BIG 1'b1
`define ESU_REQ_IDLE 1'b1
`define ESU_FIFO_DEPTH 32
`endif

/* File: src/esu_pkg.sv */
// Purpose: types shared by the endian swap and unmunge datapath
// Assumes: nothing
// Notes: structs carry one processor request and one memory/pci request
package esu_pkg;
  typedef struct packed {
    logic write;
    logic burstIndicatorN;
    logic toPci;
    logic [2:0] transferSize;
    logic [31:0] addr;
    logic [63:0] data;
  } esu_cpu_req_s;

  typedef struct packed {
    logic write;
    logic toPci;
    logic pciRefused;
    logic [31:0] addr;
    logic [63:0] data;
    logic [7:0] casN;
    logic [3:0] cbeN;
  } esu_mem_req_s;
endpackage

/* File: testbench/endian_swap_unmunge_bench.sv */
// Purpose: self-checking bench of the endian swap datapath
// Assumes: fifo depth shortened to 4
// Notes: expectations built from true address and value
`timescale 1ns/1ps
`define CHK(a, b) check_val(64'(a), 64'(b))
module endian_swap_unmunge_bench
  import esu_pkg::*;
;
  typedef struct packed {
    logic [46:0] f;
    logic [63:0] d;
    logic [63:0] m;
  } esu_exp_s;
  logic core_clk, resetn, cpuBusIdle, pciBusIdle, endianRequestN;
  logic memReqReady, rdValid, cpuReqValid, cpuReqReady, endianSelectN;
  logic memReqValid, cpuRdValid, hung, le;
  logic [63:0] rdData, cpuRdData;
  esu_cpu_req_s cpuReq;
  esu_mem_req_s memReq;
  int bad_count, checks;
  esu_exp_s expQ[$];
  wire [46:0] memFields = {memReq.write, memReq.toPci, memReq.pciRefused,
    memReq.addr, memReq.casN, memReq.cbeN};

  esu_endian_swap_unmunge #(.FIFO_DEPTH(4)) DUT (.core_clk(core_clk),
    .resetn(resetn), .cpuReqValid(cpuReqValid), .cpuReqReady(cpuReqReady),
    .cpuReq(cpuReq), .cpuBusIdle(cpuBusIdle), .pciBusIdle(pciBusIdle),
    .endianRequestN(endianRequestN), .endianSelectN(endianSelectN),
    .memReqValid(memReqValid), .memReqReady(memReqReady), .memReq(memReq),
    .rdValid(rdValid), .rdData(rdData), .cpuRdValid(cpuRdValid),
    .cpuRdData(cpuRdData));
  esu_cpu_master cpu (.core_clk(core_clk), .cpuReqReady(cpuReqReady),
    .cpuReqValid(cpuReqValid), .cpuReq(cpuReq), .hung(hung));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // ---
  // shared checking
  // ---
  task automatic check_val(logic [63:0] got, logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    if (bad_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    if (resetn && memReqValid && memReqReady) begin
      if (expQ.size() == 0) begin
        `CHK(1'b1, 1'b0);
      end else begin
        `CHK(memFields, expQ[0].f);
        `CHK(memReq.data & expQ[0].m, expQ[0].d & expQ[0].m);
        void'(expQ.pop_front());
      end
    end
  end
  // byte k of the value lands at lane a+k (little) or a+n-1-k (big)
  function automatic esu_exp_s expect_req(logic [2:0] sz,
      logic [31:0] a, logic [63:0] v, logic wr, logic pci, logic bstN);
    esu_exp_s e;
    logic [7:0] ln;
    logic [31:0] w;
    int n;
    int k;
    n = (sz == 3'h1) ? 1 : (sz == 3'h2) ? 2 : (sz == 3'h4) ? 4 :
      (sz == 3'h0) ? 8 : 0;
    ln = 8'((1 << n) - 1) << a[2:0];
    e.d = '0;
    for (k = 0; k < n; k++)
      e.d[63-8*((a[2:0] + (le ? k : n - 1 - k)) & 7) -: 8] = v[8*k +: 8];
    w = a[2] ? e.d[31:0] : e.d[63:32];
    if (n == 4) e.d = {w, w};
    for (k = 0; k < 8; k++) e.m[63-8*k -: 8] = {8{wr & (ln[k] | n == 4)}};
    e.f = {wr, pci, pci && (n == 8 || !bstN), a,
      (pci || n == 0) ? 8'hff : (!wr || !bstN || n == 8) ? 8'h00 : ~ln,
      (pci && bstN && n inside {1, 2, 4}) ? ~(ln[7:4] | ln[3:0]) : 4'hf};
    return e;
  endfunction
  task automatic send(logic [2:0] sz, logic [31:0] a, logic [63:0] v,
      logic wr, logic pci, logic bstN);
    expQ.push_back(expect_req(sz, a, v, wr, pci, bstN));
    cpu.issue(le, sz, a, v, wr, pci, bstN);
    if (hung) begin
      `CHK(hung, 1'b0);
      complete_run();
    end
  endtask
  task automatic wait_empty();
    int k;
    for (k = 0; k < 100 && expQ.size() != 0; k++) @(negedge core_clk);
    `CHK(expQ.size(), 0);
    if (expQ.size() != 0) complete_run();
  endtask
  // ---
  // scenarios
  // ---
  task automatic t_stores(logic pci);
    logic [63:0] v;
    int a;
    v = 64'h3132_3334_3536_3738;
    for (a = 0; a < 8; a++) begin
      send(3'h1, 32'h1000_0010 + a, v + a, 1'b1, pci, 1'b1);
      if (a % 2 == 0) send(3'h2, 32'h1000_0010 + a, v, 1'b1, pci, 1'b1);
      if (a % 4 == 0) send(3'h4, 32'h1000_0010 + a, v, 1'b1, pci, 1'b1);
    end
    send(3'h0, 32'h1000_0010, v, 1'b1, pci, 1'b1);
    send(3'h0, 32'h1000_0010, v, 1'b1, pci, 1'b0);
    if (!pci) send(3'h1, 32'h1000_0013, v, 1'b0, 1'b0, 1'b1);
    for (a = 3; a < 8; a++)
      if (a != 4) send(3'(a), 32'h1000_0013, v, 1'b1, pci, 1'b1);
    cpu.release_bus();
    wait_empty();
  endtask
  task automatic t_switch(logic req);
    int k;
    {cpuBusIdle, pciBusIdle} <= req ? 2'b10 : 2'b01;
    endianRequestN <= req;
    repeat (6) @(negedge core_clk);
    `CHK(endianSelectN, !req);
    {cpuBusIdle, pciBusIdle} <= 2'b11;
    for (k = 0; k < 8 && endianSelectN !== req; k++) @(negedge core_clk);
    `CHK(endianSelectN, req);
    if (endianSelectN !== req) complete_run();
    le = !req;
  endtask
  task automatic t_load();
    logic [63:0] v;
    v = 64'h1234_5678_9abc_def0;
    rdData <= v;
    rdValid <= 1'b1;
    @(negedge core_clk);
    rdValid <= 1'b0;
    rdData <= ~v;
    `CHK(cpuRdValid, 1'b1);
    `CHK(cpuRdData, le ? 64'hf0de_bc9a_7856_3412 : v);
    @(negedge core_clk);
    `CHK(cpuRdValid, 1'b0);
  endtask
  // stalled far side: request side must refuse, then drain in order
  task automatic t_fill();
    memReqReady <= 1'b0;
    fork
      begin
        for (int k = 0; k < 7; k++)
          send(3'h4, 32'h2000_0000 + 4 * k, 64'h0102_0304 + k, 1'b1,
            1'b0, 1'b1);
        cpu.release_bus();
      end
    join_none
    repeat (20) @(negedge core_clk);
    `CHK(cpuReqReady, 1'b0);
    `CHK(memReqValid, 1'b1);
    memReqReady <= 1'b1;
    repeat (4) @(negedge core_clk);
    wait_empty();
  endtask

  initial begin
    resetn = 1'b0;
    {cpuBusIdle, pciBusIdle, endianRequestN, memReqReady} = 4'hf;
    {rdValid, le} = 2'b00;
    rdData = '0;
    bad_count = 0;
    checks = 0;
    repeat (8) @(posedge core_clk);
    @(negedge core_clk);
    resetn <= 1'b1;
    @(negedge core_clk);
    `CHK({endianSelectN, cpuReqReady, memReqValid}, 3'b110);
    t_stores(1'b0);
    t_stores(1'b1);
    t_load();
    t_switch(1'b0);
    t_stores(1'b0);
    t_stores(1'b1);
    t_fill();
    t_load();
    t_switch(1'b1);
    t_load();
    `CHK(hung, 1'b0);
    complete_run();
  end
endmodule

/* File: testbench/esu_cpu_master.sv */
// Purpose: processor bus master issuing munged requests
// Assumes: request changes on falling edge, taken on rising
// Notes: released lines show the inverse of their last value
`timescale 1ns/1ps
module esu_cpu_master
  import esu_pkg::*;
(
  input wire logic core_clk,
  input wire logic cpuReqReady,
  output logic cpuReqValid,
  output esu_cpu_req_s cpuReq,
  output logic hung
);
  initial begin
    cpuReqValid = 1'b0;
    cpuReq = '0;
    hung = 1'b0;
  end
  // ---
  // callers keep transfers aligned; odd sizes only on purpose
  // ---
  task automatic issue(input logic le, input logic [2:0] sz,
      input logic [31:0] a, input logic [63:0] v, input logic wr,
      input logic pci, input logic bstN);
    logic [2:0] m;
    logic [63:0] d;
    int n;
    int k;
    n = (sz == 3'h1) ? 1 : (sz == 3'h2) ? 2 : (sz == 3'h4) ? 4 : 8;
    m = !le ? 3'h0 : (sz == 3'h1) ? 3'h7 : (sz == 3'h2) ? 3'h6 :
      (sz == 3'h4) ? 3'h4 : 3'h0;
    d = '0;
    for (k = 0; k < n; k++)
      d[63-8*(((a[2:0] ^ m) + n - 1 - k) & 7) -: 8] = v[8*k +: 8];
    @(negedge core_clk);
    cpuReq <= '{write: wr, burstIndicatorN: bstN, toPci: pci,
      transferSize: sz, addr: {a[31:3], a[2:0] ^ m}, data: d};
    cpuReqValid <= 1'b1;
    k = 0;
    while (!cpuReqReady && k < 200) begin
      @(negedge core_clk);
      k++;
    end
    if (k == 200) hung = 1'b1;
  endtask
  task automatic release_bus();
    @(negedge core_clk);
    cpuReqValid <= 1'b0;
    cpuReq <= ~cpuReq;
  endtask
endmodule
